// file: three_wire_pkg.sv
// Purpose: constants, types and helpers shared by the three-wire configuration slave
// Assumes: 16-bit word, 7-bit register address, two register pages
// Notes:   none
//
// How it works
// R1: data pin two-way, clock in, select high
// R2: every field moves most significant bit first
// R3: word is address 15:9, direction 8, data 7:0
// R4: master gives sixteen clocks per single access
// R5: direction zero writes, direction one reads
// R6: write needs setup command 12h first
// R7: master changes write bits on falling clock
// R8: master drops select after last clock
// R9: read master sends eight bits, sixteen clocks
// R10: master releases data after direction bit
// R11: device drives read byte for rising sampling
// R12: held select keeps reading further bytes
// R13: setup mode allows exactly one following operation
// R14: 81h page zero, 55h page one
// R15: block write steps address per byte
// R16: 68h clears latched fault, restarts device; the code only pulses fault_clear and drops fault_latched, nothing restarts
// R17: device samples data on rising serial clock
// R18: block read steps address per byte
package three_wire_pkg;

    // ==========================================================
    // word format
    localparam int        ADDR_W         = 7;
    localparam int        DATA_W         = 8;
    localparam int        WORD_ADDR_MSB  = 15;
    localparam int        WORD_DIR_BIT   = 8;
    localparam logic [2:0] FIELD_LAST    = 3'h7;
    localparam logic      DIR_WRITE      = 1'b0;
    localparam logic      DIR_READ       = 1'b1;

    // ==========================================================
    // register map
    localparam logic [6:0] MODE_ADDR     = 7'h00;
    localparam logic [6:0] STATUS_ADDR   = 7'h7F;
    localparam logic      PAGE_RESET     = 1'b1;
    localparam logic [7:0] REG_RESET     = 8'h00;

    // ==========================================================
    // mode command codes
    localparam logic [7:0] CMD_NORMAL    = 8'h00;
    localparam logic [7:0] CMD_SETUP     = 8'h12;
    localparam logic [7:0] CMD_PAGE1     = 8'h55;
    localparam logic [7:0] CMD_FAULT_CLR = 8'h68;
    localparam logic [7:0] CMD_PAGE0     = 8'h81;

    // ==========================================================
    // crossing event kinds
    localparam logic      EV_REG_WRITE   = 1'b0;
    localparam logic      EV_FAULT_CLEAR = 1'b1;

    typedef enum logic [1:0] {
        PH_HDR   = 2'b00,
        PH_WDATA = 2'b01,
        PH_RDATA = 2'b10
    } link_phase_e;

    // ==========================================================
    // helpers
    function automatic logic is_read_only(input logic [6:0] addr);
        return addr == STATUS_ADDR;
    endfunction

    function automatic logic [6:0] next_addr(input logic [6:0] addr);
        return addr + 7'h01;
    endfunction

endpackage

// file: write_event_if.sv
// Purpose: carries one written byte or command from the link domain to the core domain
// Assumes: fields held stable from a toggle until the next toggle
// Notes:   toggle crosses by synchroniser, fields are read only after it
`timescale 1ns/1ps
interface write_event_if;
    logic       toggle;
    logic       kind;
    logic       page;
    logic [6:0] addr;
    logic [7:0] data;

    modport tx (output toggle, output kind, output page, output addr, output data);
    modport rx (input toggle, input kind, input page, input addr, input data);
endinterface

// file: bit_sync.sv
// Purpose: two flip-flop synchroniser for levels
// Assumes: each bit changes slowly against clk
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module bit_sync
    import three_wire_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // level in and out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule // bit_sync

// file: write_event_rx.sv
// Purpose: turns link-domain event toggles into core-domain pulses
// Assumes: events spaced at least eight serial clocks apart
// Notes:   fields sampled when the synchronised toggle changes
`timescale 1ns/1ps
module write_event_rx
    import three_wire_pkg::*;
(
    // clock and reset
    input  wire logic  clk,
    input  wire logic  rst_n,
    // link side
    write_event_if.rx  ev,
    // core side
    output logic       wr_valid,
    output logic       wr_page,
    output logic [6:0] wr_addr,
    output logic [7:0] wr_data,
    output logic       clr_pulse
);

    logic tog_sync;
    logic tog_last_reg;
    logic edge_seen;

    bit_sync #(.WIDTH(1)) u_tog_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (ev.toggle),
        .q     (tog_sync)
    );

    assign edge_seen = tog_sync ^ tog_last_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_last_reg <= 1'b0;
            wr_valid     <= 1'b0;
            clr_pulse    <= 1'b0;
            wr_page      <= PAGE_RESET;
            wr_addr      <= '0;
            wr_data      <= '0;
        end else begin
            tog_last_reg <= tog_sync;
            wr_valid     <= edge_seen && (ev.kind == EV_REG_WRITE);
            clr_pulse    <= edge_seen && (ev.kind == EV_FAULT_CLEAR); // R16
            if (edge_seen && (ev.kind == EV_REG_WRITE)) begin
                wr_page <= ev.page;
                wr_addr <= ev.addr;
                wr_data <= ev.data;
            end
        end
    end

endmodule // write_event_rx

// file: three_wire_config_slave.sv
// Purpose: three-wire serial configuration slave with paged registers
// Assumes: clk 25 MHz; serial clock from the master, idle outside frames
// Notes:   register storage lives on the serial clock; writes cross to clk
`timescale 1ns/1ps
module three_wire_config_slave
    import three_wire_pkg::*;
(
    // system clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // serial link
    input  wire logic       sclk,
    input  wire logic       select_strobe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // core status
    input  wire logic       fault_in,
    input  wire logic [6:0] status_in,
    // core configuration updates
    output logic            cfg_wr_valid,
    output logic            cfg_wr_page,
    output logic [6:0]      cfg_wr_addr,
    output logic [7:0]      cfg_wr_data,
    output logic            fault_clear,
    output logic            fault_latched
);

    // ==========================================================
    // reset release
    logic rst_meta_reg;
    logic rst_sync_n;
    logic link_rst_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n   <= rst_meta_reg;
        end
    end

    // frame logic is held clear whenever select is low
    assign link_rst_n = rst_sync_n & select_strobe; // R1 R12

    // ==========================================================
    // core-side status and fault latch
    logic [7:0] core_in_sync;
    logic [7:0] status_core_reg;
    logic       clr_pulse;

    bit_sync #(.WIDTH(8)) u_core_in_sync (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .d     ({fault_in, status_in}),
        .q     (core_in_sync)
    );

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fault_latched <= 1'b0;
        end else if (core_in_sync[7]) begin
            fault_latched <= 1'b1;
        end else if (clr_pulse) begin
            fault_latched <= 1'b0; // R16
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            status_core_reg <= '0;
            fault_clear     <= 1'b0;
        end else begin
            status_core_reg <= {fault_latched, core_in_sync[6:0]};
            fault_clear     <= clr_pulse; // R16
        end
    end

    // ==========================================================
    // link-domain copy of status
    logic [7:0] status_link;

    bit_sync #(.WIDTH(8)) u_status_link_sync (
        .clk   (sclk),
        .rst_n (rst_sync_n),
        .d     (status_core_reg),
        .q     (status_link)
    );

    // ==========================================================
    // frame state
    link_phase_e phase_reg;
    logic [2:0]  cnt_reg;
    logic [6:0]  shift_reg;
    logic [6:0]  cur_addr_reg;
    logic [7:0]  tx_shift_reg;

    // persistent link state
    logic        page_reg;
    logic        pending_reg;
    logic        frame_wr_ok_reg;
    logic [7:0]  mode_code_reg;
    logic [7:0]  regs_mem [0:255];

    logic        hdr_done;
    logic        wbyte_done;
    logic        rbyte_done;
    logic [6:0]  hdr_addr;
    logic        hdr_dir;
    logic [7:0]  rx_byte;
    logic        mode_hit;
    logic        cfg_write;
    logic        cmd_setup;
    logic        cmd_normal;
    logic        cmd_page0;
    logic        cmd_page1;
    logic        cmd_clear;

    function automatic logic [7:0] read_value(input logic pg, input logic [6:0] addr);
        if (addr == MODE_ADDR) begin
            return mode_code_reg;
        end else if (addr == STATUS_ADDR) begin
            return status_link;
        end
        return regs_mem[{pg, addr}];
    endfunction

    assign hdr_done   = (phase_reg == PH_HDR) && (cnt_reg == FIELD_LAST);
    assign wbyte_done = (phase_reg == PH_WDATA) && (cnt_reg == FIELD_LAST);
    assign rbyte_done = (phase_reg == PH_RDATA) && (cnt_reg == FIELD_LAST);
    assign hdr_addr   = shift_reg; // R3
    assign hdr_dir    = sda_in; // R3
    assign rx_byte    = {shift_reg, sda_in}; // R2
    assign mode_hit   = wbyte_done && (cur_addr_reg == MODE_ADDR);
    assign cfg_write  = wbyte_done && (cur_addr_reg != MODE_ADDR) && frame_wr_ok_reg
                        && !is_read_only(cur_addr_reg); // R6 R13
    assign cmd_setup  = mode_hit && (rx_byte == CMD_SETUP); // R6
    assign cmd_normal = mode_hit && (rx_byte == CMD_NORMAL);
    assign cmd_page0  = mode_hit && (rx_byte == CMD_PAGE0); // R14
    assign cmd_page1  = mode_hit && (rx_byte == CMD_PAGE1); // R14
    assign cmd_clear  = mode_hit && (rx_byte == CMD_FAULT_CLR); // R16

    // ==========================================================
    // serial receive and address sequencing
    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            phase_reg    <= PH_HDR;
            cnt_reg      <= '0;
            shift_reg    <= '0;
            cur_addr_reg <= '0;
        end else begin
            cnt_reg   <= cnt_reg + 3'h1;
            shift_reg <= {shift_reg[5:0], sda_in}; // R17 R2
            unique case (phase_reg)
                PH_HDR: begin
                    if (hdr_done) begin
                        cur_addr_reg <= hdr_addr;
                        phase_reg    <= (hdr_dir == DIR_READ) ? PH_RDATA : PH_WDATA; // R5
                    end
                end
                PH_WDATA: begin
                    if (wbyte_done) begin
                        cur_addr_reg <= next_addr(cur_addr_reg); // R15
                    end
                end
                PH_RDATA: begin
                    if (rbyte_done) begin
                        cur_addr_reg <= next_addr(cur_addr_reg); // R18 R12
                    end
                end
                default: begin
                    phase_reg <= PH_HDR;
                end
            endcase
        end
    end

    // ==========================================================
    // read data shifter
    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_shift_reg <= '0;
        end else if (hdr_done && (hdr_dir == DIR_READ)) begin
            tx_shift_reg <= read_value(page_reg, hdr_addr); // R11
        end else if (rbyte_done) begin
            tx_shift_reg <= read_value(page_reg, next_addr(cur_addr_reg)); // R18 R12
        end else begin
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0}; // R2
        end
    end

    // drive on falling edge so each bit is steady at the next rising edge
    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            sda_out <= tx_shift_reg[7]; // R11
            sda_oe  <= (phase_reg == PH_RDATA); // R10 R11
        end
    end

    // ==========================================================
    // mode commands and one-shot setup
    always_ff @(posedge sclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_code_reg <= CMD_NORMAL;
        end else if (mode_hit) begin
            mode_code_reg <= rx_byte;
        end
    end

    always_ff @(posedge sclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            page_reg <= PAGE_RESET; // R14
        end else if (cmd_page0) begin
            page_reg <= 1'b0; // R14
        end else if (cmd_page1) begin
            page_reg <= 1'b1; // R14
        end
    end

    // armed by setup, consumed by the next header, the first accepted write or a normal command
    always_ff @(posedge sclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pending_reg <= 1'b0;
        end else if (cmd_setup) begin
            pending_reg <= 1'b1; // R6
        end else if (hdr_done || cfg_write || cmd_normal) begin
            pending_reg <= 1'b0; // R13
        end
    end

    always_ff @(posedge sclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            frame_wr_ok_reg <= 1'b0;
        end else if (hdr_done) begin
            frame_wr_ok_reg <= pending_reg; // R13
        end else if (cmd_setup) begin
            frame_wr_ok_reg <= 1'b1; // R15
        end else if (cmd_normal) begin
            frame_wr_ok_reg <= 1'b0;
        end
    end

    // ==========================================================
    // register storage
    always_ff @(posedge sclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < 256; i++) begin
                regs_mem[i] <= REG_RESET;
            end
        end else if (cfg_write) begin
            regs_mem[{page_reg, cur_addr_reg}] <= rx_byte; // R6 R15
        end
    end

    // ==========================================================
    // events toward the core
    write_event_if ev_if ();

    logic       ev_toggle_reg;
    logic       ev_kind_reg;
    logic       ev_page_reg;
    logic [6:0] ev_addr_reg;
    logic [7:0] ev_data_reg;

    always_ff @(posedge sclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ev_toggle_reg <= 1'b0;
            ev_kind_reg   <= EV_REG_WRITE;
            ev_page_reg   <= PAGE_RESET;
            ev_addr_reg   <= '0;
            ev_data_reg   <= '0;
        end else if (cfg_write) begin
            ev_toggle_reg <= ~ev_toggle_reg;
            ev_kind_reg   <= EV_REG_WRITE;
            ev_page_reg   <= page_reg;
            ev_addr_reg   <= cur_addr_reg;
            ev_data_reg   <= rx_byte;
        end else if (cmd_clear) begin
            ev_toggle_reg <= ~ev_toggle_reg; // R16
            ev_kind_reg   <= EV_FAULT_CLEAR;
        end
    end

    assign ev_if.toggle = ev_toggle_reg;
    assign ev_if.kind   = ev_kind_reg;
    assign ev_if.page   = ev_page_reg;
    assign ev_if.addr   = ev_addr_reg;
    assign ev_if.data   = ev_data_reg;

    write_event_rx u_event_rx (
        .clk       (clk),
        .rst_n     (rst_sync_n),
        .ev        (ev_if.rx),
        .wr_valid  (cfg_wr_valid),
        .wr_page   (cfg_wr_page),
        .wr_addr   (cfg_wr_addr),
        .wr_data   (cfg_wr_data),
        .clr_pulse (clr_pulse)
    );

endmodule // three_wire_config_slave

// file: three_wire_config_slave_monitor.sv
// Purpose: concurrent checks on the three-wire slave ports
// Assumes: serial clock idle low between frames
// Notes:   bound to every slave instance
`timescale 1ns/1ps
module three_wire_config_slave_monitor
    import three_wire_pkg::*;
(
    // clocks and reset
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       sclk,
    // serial link
    input wire logic       select_strobe,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    // core side
    input wire logic       fault_in,
    input wire logic [6:0] status_in,
    input wire logic       cfg_wr_valid,
    input wire logic       cfg_wr_page,
    input wire logic [6:0] cfg_wr_addr,
    input wire logic [7:0] cfg_wr_data,
    input wire logic       fault_clear,
    input wire logic       fault_latched
);
    // ==========================================================
    // frame tracking
    logic [7:0] edge_cnt;
    logic       rd_frame;

    always_ff @(posedge sclk or negedge select_strobe) begin
        if (!select_strobe) edge_cnt <= 8'h00;
        else if (edge_cnt != 8'hFF) edge_cnt <= edge_cnt + 8'h01;
    end

    always_ff @(posedge sclk or negedge select_strobe) begin
        if (!select_strobe) rd_frame <= 1'b0;
        else if (edge_cnt == 8'h07) rd_frame <= sda_in;
    end

    a_oe_after_header: assert property (@(posedge sclk) disable iff (!rst_n || !select_strobe)
        sda_oe |-> edge_cnt >= 8'h08) else $error("data driven during header");
    a_oe_read_only: assert property (@(posedge sclk) disable iff (!rst_n || !select_strobe)
        sda_oe |-> rd_frame) else $error("data driven in write frame");
    a_oe_read_data: assert property (@(posedge sclk) disable iff (!rst_n || !select_strobe)
        (edge_cnt >= 8'h08 && rd_frame) |-> sda_oe) else $error("read data not driven");
    a_oe_drop_select: assert property (@(posedge clk) disable iff (!rst_n)
        !select_strobe |-> !sda_oe) else $error("data driven without select");
    a_wr_one_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_wr_valid |=> !cfg_wr_valid) else $error("write pulse too long");
    a_clear_one_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        fault_clear |=> !fault_clear) else $error("clear pulse too long");
    a_fault_latches: assert property (@(posedge clk) disable iff (!rst_n)
        fault_in [*8] |-> fault_latched) else $error("fault not latched");
    a_page_after_reset: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> cfg_wr_page) else $error("page not one after reset");
    a_wr_fields_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !cfg_wr_valid |-> $stable(cfg_wr_addr) && $stable(cfg_wr_data) && $stable(cfg_wr_page))
        else $error("write fields moved without pulse");
endmodule // three_wire_config_slave_monitor

bind three_wire_config_slave three_wire_config_slave_monitor u_mon (.clk(clk), .rst_n(rst_n), .sclk(sclk),
    .select_strobe(select_strobe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .fault_in(fault_in),
    .status_in(status_in), .cfg_wr_valid(cfg_wr_valid), .cfg_wr_page(cfg_wr_page), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_data(cfg_wr_data), .fault_clear(fault_clear), .fault_latched(fault_latched));

// file: serial_master_model.sv
// Purpose: serial bus master driving frames into the slave
// Assumes: 64 ns serial clock, idle low outside frames
// Notes:   one frame at a time, called from the bench
`timescale 1ns/1ps
module serial_master_model (
    // serial link
    output logic      sclk,
    output logic      select_strobe,
    output logic      sda_drive,
    output logic      sda_drive_oe,
    input  wire logic sda
);
    initial begin
        sclk = 1'b0;
        select_strobe = 1'b0;
        sda_drive = 1'b0;
        sda_drive_oe = 1'b0;
    end

    // ==========================================================
    // one frame: header then nb data bytes
    task automatic frame(input logic [6:0] a, input logic dir, input logic [15:0] wd, input int nb,
                         output logic [15:0] rd);
        logic [7:0] hdr;
        int         i;
        hdr = {a, dir};
        rd = 16'h0000;
        #7 select_strobe = 1'b1;
        sda_drive_oe = 1'b1;
        sda_drive = hdr[7];
        #32;
        for (i = 0; i < 8 + 8 * nb; i++) begin
            sclk = 1'b1;
            if (i >= 8) rd = {rd[14:0], sda};
            #32 sclk = 1'b0;
            if (i < 7) sda_drive = hdr[6-i];
            else if (dir) sda_drive_oe = 1'b0;
            else if (i < 7 + 8 * nb) sda_drive = wd[22-i];
            #32;
        end
        select_strobe = 1'b0;
        sda_drive_oe = 1'b0;
        #64;
    endtask
endmodule // serial_master_model

// file: three_wire_config_slave_bench.sv
// Purpose: self-checking bench for the three-wire slave
// Assumes: master model owns the link clock
// Notes:   released data line shows the inverse of the last master bit
`timescale 1ns/1ps
module three_wire_config_slave_bench;
    import three_wire_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, fault_in = 1'b0;
    logic [6:0] status_in = 7'h00, cfg_wr_addr;
    logic [7:0] cfg_wr_data;
    logic sclk, sel, md, moe, sda_in, sda_out, sda_oe, cfg_wr_valid, cfg_wr_page, fault_clear, fault_latched;
    logic [15:0] r;
    int err_count = 0, check_count = 0, wr_cnt = 0, clr_cnt = 0, n, i;
    logic [7:0] codes [5] = '{8'h55, 8'h12, 8'h68, 8'h00, 8'h81};

    always #20 clk = ~clk;
    assign sda_in = sda_oe ? sda_out : (moe ? md : ~md);
    always @(posedge clk) if (cfg_wr_valid === 1'b1) wr_cnt <= wr_cnt + 1;
    always @(posedge clk) if (fault_clear === 1'b1) clr_cnt <= clr_cnt + 1;

    three_wire_config_slave uut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .select_strobe(sel), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .fault_in(fault_in), .status_in(status_in),
        .cfg_wr_valid(cfg_wr_valid), .cfg_wr_page(cfg_wr_page), .cfg_wr_addr(cfg_wr_addr),
        .cfg_wr_data(cfg_wr_data), .fault_clear(fault_clear), .fault_latched(fault_latched));
    serial_master_model mst (.sclk(sclk), .select_strobe(sel), .sda_drive(md), .sda_drive_oe(moe), .sda(sda_in));

    // ==========================================================
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        mst.frame(a, DIR_WRITE, {d, 8'h00}, 1, r);
        repeat (8) @(posedge clk);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string msg);
        mst.frame(a, DIR_READ, 16'h0000, 1, r);
        check(r[7:0], exp, msg);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_mode;
        for (i = 0; i < 5; i++) begin
            wr(MODE_ADDR, codes[i]);
            rd(MODE_ADDR, codes[i], "mode readback");
        end
        check(16'(clr_cnt), 16'h0001, "fault clear count");
        $display("test mode done");
    endtask
    task automatic t_setup;
        n = wr_cnt;
        wr(7'h05, 8'hA5);
        check(16'(wr_cnt), 16'(n), "write without setup");
        wr(MODE_ADDR, CMD_SETUP);
        wr(7'h05, 8'hA5);
        check({cfg_wr_page, cfg_wr_addr, cfg_wr_data}, {1'b0, 7'h05, 8'hA5}, "setup write");
        wr(7'h06, 8'h5A);
        check(16'(wr_cnt), 16'(n + 1), "one shot setup");
        wr(MODE_ADDR, CMD_SETUP);
        n = wr_cnt;
        mst.frame(MODE_ADDR, DIR_WRITE, {CMD_NORMAL, 8'h5A}, 2, r);
        repeat (8) @(posedge clk);
        check(16'(wr_cnt), 16'(n), "normal cancels setup");
        rd(7'h05, 8'hA5, "read back");
        $display("test setup done");
    endtask
    task automatic t_block;
        mst.frame(MODE_ADDR, DIR_WRITE, {CMD_SETUP, 8'h3C}, 2, r);
        repeat (8) @(posedge clk);
        check({cfg_wr_addr, cfg_wr_data}, {7'h01, 8'h3C}, "block mode one");
        wr(MODE_ADDR, CMD_SETUP);
        n = wr_cnt;
        mst.frame(7'h10, DIR_WRITE, 16'h1122, 2, r);
        repeat (8) @(posedge clk);
        check({cfg_wr_addr, cfg_wr_data}, {7'h11, 8'h22}, "block mode two");
        check(16'(wr_cnt), 16'(n + 2), "block write count");
        mst.frame(7'h10, DIR_READ, 16'h0000, 2, r);
        check(r, 16'h1122, "block read");
        $display("test block done");
    endtask
    task automatic t_page;
        wr(MODE_ADDR, CMD_PAGE1);
        wr(MODE_ADDR, CMD_SETUP);
        wr(7'h10, 8'h77);
        check(cfg_wr_page, 1'b1, "page one write");
        rd(7'h10, 8'h77, "page one read");
        wr(MODE_ADDR, CMD_PAGE0);
        rd(7'h10, 8'h11, "page zero kept");
        $display("test page done");
    endtask
    task automatic t_fault;
        @(posedge clk) status_in <= 7'h2A;
        fault_in <= 1'b1;
        repeat (10) @(posedge clk);
        fault_in <= 1'b0;
        repeat (6) @(posedge clk);
        check(fault_latched, 1'b1, "fault latched");
        rd(STATUS_ADDR, 8'hAA, "status read");
        n = wr_cnt;
        wr(MODE_ADDR, CMD_SETUP);
        wr(STATUS_ADDR, 8'hFF);
        check(16'(wr_cnt), 16'(n), "status write refused");
        wr(MODE_ADDR, CMD_FAULT_CLR);
        check(fault_latched, 1'b0, "fault cleared");
        check(16'(clr_cnt), 16'h0002, "clear pulse");
        $display("test fault done");
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check({cfg_wr_page, sda_oe, fault_latched}, 3'b100, "reset state");
        t_mode;
        t_setup;
        t_block;
        t_page;
        t_fault;
        report_and_stop;
    end

    initial begin
        #300000;
        err_count++;
        report_and_stop;
    end
endmodule // three_wire_config_slave_bench
